/* inc/dpc_defines.svh */
// Constants of the diagnostic pulse, configuration and status register bank
`ifndef DPC_DEFINES_SVH
`define DPC_DEFINES_SVH
// ==========================================================================
// Frame layout and register addresses
`define DPC_FRAME_BITS 16
`define DPC_CNT_MAX 5'h11
`define DPC_ADDR_PULSE 3'h1
`define DPC_ADDR_CFG1 3'h2
`define DPC_ADDR_CFG2 3'h3
`define DPC_ADDR_STLO 3'h4
`define DPC_ADDR_STHI 3'h5
`define DPC_NCH 6
`define DPC_HALF 3
// ==========================================================================
// Field positions
`define DPC_ON_REQ 5:0
`define DPC_OFF_REQ 11:6
`define DPC_CHSEL 2:0
`define DPC_BLANK_ON 6:5
`define DPC_BLANK_OFF 8:7
`define DPC_REF_SEL 11:9
`define DPC_OL_EN 5:0
`define DPC_FC_EN 11:6
`define DPC_ST_DIS_BIT 9
`define DPC_ST_ZERO 11:10
// ==========================================================================
// Reset values and codes
`define DPC_PULSE_RST 12'h000
`define DPC_CFG1_RST 12'h147
`define DPC_CFG2_RST 12'h03f
`define DPC_CHSEL_NONE 3'h0
`define DPC_CHSEL_ALL 3'h7
`define DPC_REF_RST 3'h0
`define DPC_BL_RST 2'h2
`define DPC_ST_INVALID 3'h0
`define DPC_ST_SCB 3'h1
`define DPC_ST_OLF 3'h3
`define DPC_ST_NOT_DONE 3'h7
// ==========================================================================
// Timing: clock rate and blanking times in microseconds
`define DPC_CLK_MHZ 25
`define DPC_TMR_W 14
`define DPC_T_ON0_US 6
`define DPC_T_ON1_US 12
`define DPC_T_ON2_US 24
`define DPC_T_ON3_US 48
`define DPC_T_OFF0_US 55
`define DPC_T_OFF1_US 81
`define DPC_T_OFF2_US 162
`define DPC_T_OFF3_US 325
`endif

/* inc/dpc_pkg.sv */
// Types shared by the register bank, its serial link and its channels
`include "dpc_defines.svh"
package dpc_pkg;
  // ========================================================================
  // Serial frame: address, twelve data bits, parity
  typedef struct packed {
    logic [2:0] addr;
    logic [11:0] data;
    logic parity;
  } dpc_frame_type;

  // ========================================================================
  // Per-channel configuration held from the first configuration register
  typedef struct packed {
    logic [2:0] ref_sel;
    logic [1:0] off_sel;
    logic [1:0] on_sel;
  } dpc_cfg_type;

  // ========================================================================
  // Pulse engine states
  typedef enum logic [1:0] {
    dpc_idle = 2'b00,
    dpc_on_pulse = 2'b01,
    dpc_off_pulse = 2'b10
  } dpc_state_type;
endpackage

/* design/dpc_link.sv */
// Serial link shifter running on the host's serial clock
`timescale 1ns/10ps
module dpc_link (
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_mosi,
  input wire logic [15:0] i_resp,
  output logic o_miso,
  output logic o_miso_oe,
  output dpc_pkg::dpc_frame_type o_frame,
  output logic o_frame_ok
);
  logic [4:0] cnt_q;
  logic [15:0] rx_q;
  logic [15:0] tx_q;
  logic got_q;

  // ========================================================================
  // Bit counter, cleared by chip select so it never needs a clock edge
  wire frame_rst_n = i_arst_n & ~i_chip_select_n;
  wire last_bit = (cnt_q == 5'(`DPC_FRAME_BITS - 1));
  wire first_bit = (cnt_q == 5'h00);
  always_ff @(posedge i_sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) cnt_q <= 5'h00;
    else if (cnt_q != `DPC_CNT_MAX) cnt_q <= cnt_q + 5'h01;
  end

  // Receive shifter; got_q stays high only if exactly sixteen bits came
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_q <= 16'h0000;
      got_q <= 1'b0;
    end else begin
      rx_q <= {rx_q[14:0], i_mosi};
      got_q <= last_bit;
    end
  end

  // Transmit shifter; the answer word is static while a frame runs
  always_ff @(posedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) tx_q <= 16'h0000;
    else if (first_bit) tx_q <= {i_resp[14:0], 1'b0};
    else tx_q <= {tx_q[14:0], 1'b0};
  end

  // Odd parity over the whole word; the frame is only read after the
  // chip select rise has been synchronised, when the shifter is idle
  assign o_miso = first_bit ? i_resp[15] : tx_q[15];
  assign o_miso_oe = ~i_chip_select_n;
  assign o_frame = dpc_pkg::dpc_frame_type'(rx_q);
  assign o_frame_ok = got_q & (^rx_q);
endmodule

/* design/dpc_chan.sv */
// One channel's diagnostic pulse engine with its blanking timer
`timescale 1ns/10ps
module dpc_chan (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_abort,
  input wire logic i_launch_on,
  input wire logic i_launch_off,
  input wire logic [`DPC_TMR_W-1:0] i_on_cyc,
  input wire logic [`DPC_TMR_W-1:0] i_off_cyc,
  output logic o_active,
  output logic o_off_pulse,
  output logic o_done
);
  dpc_pkg::dpc_state_type state_q, state_d;
  logic [`DPC_TMR_W-1:0] tmr_q, tmr_d;

  wire at_end = (state_q != dpc_pkg::dpc_idle) && (tmr_q == '0);

  // ========================================================================
  // Length is fixed at launch, so a later setting change waits
  always_comb begin
    state_d = state_q;
    tmr_d = tmr_q;
    case (state_q)
      dpc_pkg::dpc_idle: begin
        if (i_abort) state_d = dpc_pkg::dpc_idle;
        else if (i_launch_on) begin
          state_d = dpc_pkg::dpc_on_pulse;
          tmr_d = i_on_cyc - 1'b1;
        end else if (i_launch_off) begin
          state_d = dpc_pkg::dpc_off_pulse;
          tmr_d = i_off_cyc - 1'b1;
        end
      end
      dpc_pkg::dpc_on_pulse, dpc_pkg::dpc_off_pulse: begin
        if (i_abort || at_end) state_d = dpc_pkg::dpc_idle;
        else tmr_d = tmr_q - 1'b1;
      end
      default: state_d = dpc_pkg::dpc_idle;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_q <= dpc_pkg::dpc_idle;
      tmr_q <= '0;
    end else begin
      state_q <= state_d;
      tmr_q <= tmr_d;
    end
  end

  // Done marks the last pulse cycle, while the pulse kind is still visible
  assign o_active = (state_q != dpc_pkg::dpc_idle);
  assign o_off_pulse = (state_q == dpc_pkg::dpc_off_pulse);
  assign o_done = at_end & ~i_abort;

  // ========================================================================
  // Checks
  chk_pulse_returns: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    o_done |=> !o_active) else $error("pulse did not end");
  chk_abort_idle: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    i_abort |=> !o_active) else $error("abort left pulse");
  chk_len_frozen: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (o_active && !i_abort && !at_end) |=> (tmr_q == $past(tmr_q) - 1'b1))
    else $error("blanking timer reloaded");
endmodule

/* design/dpc_regs.sv */
// Diagnostic pulse, configuration and status registers of six channels
`timescale 1ns/10ps
// Summary of operation
// - Pulses launch at chip select rising edge
// - Pulse register resets zero, echoes, any mode
// - Pulses ignore input and gate state
// - Skip on disable, both, short, busy, retry
// - Off pulse: open load, flip; fast charge as configured
// - On pulse flips output for blanking
// - Channel select field picks configured channels
// - Two-bit codes select on/off blanking
// - Three-bit code selects fault reference
// - New blanking applies at next start
// - First configuration echoes, defaults from encodings
// - Open load enables set, charge cleared
// - Disabled open load hides only open-load
// - Status layout: zeros, disable, codes
// - Codes ranked one highest, seven lowest
// - Reset and read give not complete
// - Keep highest priority code per channel
// - Read or master reset clears status
// - Disable aborts pulses, keeps status
// - Master reset restores all defaults
module dpc_regs #(
  parameter int OFF_BLANK_LONG_CYC = `DPC_T_OFF3_US * `DPC_CLK_MHZ
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_chip_select_n,
  input wire logic i_mosi,
  output logic o_miso,
  output logic o_miso_oe,
  input wire logic i_master_reset_n,
  input wire logic i_global_disable_input,
  input wire logic [5:0] i_retry_active,
  input wire logic [5:0] i_blank_active,
  input wire logic [5:0] i_result_valid,
  input wire logic [17:0] i_result_code,
  output logic [5:0] o_pulse_invert,
  output logic [5:0] o_off_pulse,
  output logic [5:0] o_openload_en,
  output logic [5:0] o_fast_charge_en,
  output dpc_pkg::dpc_cfg_type [5:0] o_ch_cfg
);
  // ========================================================================
  // Blanking code to cycle count; longest off setting is a parameter
  function automatic logic [`DPC_TMR_W-1:0] on_cycles(input logic [1:0] s);
    case (s)
      2'h0: on_cycles = `DPC_TMR_W'(`DPC_T_ON0_US * `DPC_CLK_MHZ);
      2'h1: on_cycles = `DPC_TMR_W'(`DPC_T_ON1_US * `DPC_CLK_MHZ);
      2'h2: on_cycles = `DPC_TMR_W'(`DPC_T_ON2_US * `DPC_CLK_MHZ);
      default: on_cycles = `DPC_TMR_W'(`DPC_T_ON3_US * `DPC_CLK_MHZ);
    endcase
  endfunction

  function automatic logic [`DPC_TMR_W-1:0] off_cycles(input logic [1:0] s);
    case (s)
      2'h0: off_cycles = `DPC_TMR_W'(`DPC_T_OFF0_US * `DPC_CLK_MHZ);
      2'h1: off_cycles = `DPC_TMR_W'(`DPC_T_OFF1_US * `DPC_CLK_MHZ);
      2'h2: off_cycles = `DPC_TMR_W'(`DPC_T_OFF2_US * `DPC_CLK_MHZ);
      default: off_cycles = `DPC_TMR_W'(OFF_BLANK_LONG_CYC);
    endcase
  endfunction

  // Odd parity bit for an answer frame
  function automatic logic odd_par(input logic [14:0] w);
    odd_par = ~(^w);
  endfunction

  // ========================================================================
  // Pin synchronisers; the third chip select stage feeds the edge detect
  logic cs_s1_q, cs_s2_q, cs_s3_q;
  logic mr_s1_q, mr_s2_q;
  logic ds_s1_q, ds_s2_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= 3'h7;
      {mr_s1_q, mr_s2_q} <= 2'h0;
      {ds_s1_q, ds_s2_q} <= 2'h3;
    end else begin
      {cs_s1_q, cs_s2_q, cs_s3_q} <= {i_chip_select_n, cs_s1_q, cs_s2_q};
      {mr_s1_q, mr_s2_q} <= {i_master_reset_n, mr_s1_q};
      {ds_s1_q, ds_s2_q} <= {i_global_disable_input, ds_s1_q};
    end
  end

  // ========================================================================
  // Serial link on the host clock
  dpc_pkg::dpc_frame_type rx_frame;
  dpc_pkg::dpc_frame_type resp_q, resp_d;
  logic rx_ok;
  dpc_link u_link (
    .i_arst_n(i_arst_n),
    .i_sclk(i_sclk),
    .i_chip_select_n(i_chip_select_n),
    .i_mosi(i_mosi),
    .i_resp(resp_q),
    .o_miso(o_miso),
    .o_miso_oe(o_miso_oe),
    .o_frame(rx_frame),
    .o_frame_ok(rx_ok)
  );

  // ========================================================================
  // Frame decode at the synchronised chip select rise
  wire srst = ~mr_s2_q;
  wire dis = ds_s2_q;
  wire frame_end = cs_s2_q & ~cs_s3_q & ~srst;
  wire frame_good = frame_end & rx_ok;
  wire [11:0] wdata = rx_frame.data;
  wire wr_pulse = frame_good & (rx_frame.addr == `DPC_ADDR_PULSE);
  wire wr_cfg1 = frame_good & (rx_frame.addr == `DPC_ADDR_CFG1);
  wire wr_cfg2 = frame_good & (rx_frame.addr == `DPC_ADDR_CFG2);
  wire rd_lo = frame_good & (rx_frame.addr == `DPC_ADDR_STLO);
  wire rd_hi = frame_good & (rx_frame.addr == `DPC_ADDR_STHI);

  // ========================================================================
  // Echo registers
  logic [11:0] pulse_q, cfg1_q, cfg2_q;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pulse_q <= `DPC_PULSE_RST;
      cfg1_q <= `DPC_CFG1_RST;
      cfg2_q <= `DPC_CFG2_RST;
    end else if (srst) begin
      pulse_q <= `DPC_PULSE_RST;
      cfg1_q <= `DPC_CFG1_RST;
      cfg2_q <= `DPC_CFG2_RST;
    end else begin
      if (wr_pulse) pulse_q <= wdata;
      if (wr_cfg1) cfg1_q <= wdata;
      if (wr_cfg2) cfg2_q <= wdata;
    end
  end

  // Incoming configuration fields; bits 4:3 are never looked at
  dpc_pkg::dpc_cfg_type cfg_new;
  assign cfg_new.ref_sel = wdata[`DPC_REF_SEL];
  assign cfg_new.off_sel = wdata[`DPC_BLANK_OFF];
  assign cfg_new.on_sel = wdata[`DPC_BLANK_ON];
  // A constant, so the asynchronous reset branches load no logic value
  localparam dpc_pkg::dpc_cfg_type cfg_rst = '{ref_sel: `DPC_REF_RST,
    off_sel: `DPC_BL_RST, on_sel: `DPC_BL_RST};
  wire [2:0] chsel = wdata[`DPC_CHSEL];
  wire [5:0] ol_cfg = cfg2_q[`DPC_OL_EN];
  wire [5:0] on_req = wdata[`DPC_ON_REQ];
  wire [5:0] off_req = wdata[`DPC_OFF_REQ];

  // ========================================================================
  // Per-channel configuration, pulse engine and status
  dpc_pkg::dpc_cfg_type [5:0] cfg_q;
  logic [5:0][2:0] st_q;
  logic [5:0] launch_on, launch_off, busy, done, accept, ol_eff;

  genvar ch;
  generate
    for (ch = 0; ch < `DPC_NCH; ch++) begin : g_ch
      // Channel hit: code equal to channel plus one, or the all code
      wire sel = (chsel == `DPC_CHSEL_ALL) || (chsel == 3'(ch + 1));
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) cfg_q[ch] <= cfg_rst;
        else if (srst) cfg_q[ch] <= cfg_rst;
        else if (wr_cfg1 && sel) cfg_q[ch] <= cfg_new;
      end

      // Skip conditions; input, gate bit and gate level play no part
      // here, so a pulse overrides commanded operation
      wire both = on_req[ch] & off_req[ch];
      wire held_scb = (st_q[ch] == `DPC_ST_SCB);
      wire ok = wr_pulse & ~dis & ~both & ~held_scb & ~busy[ch] &
        ~i_blank_active[ch] & ~i_retry_active[ch];
      assign launch_on[ch] = ok & on_req[ch];
      assign launch_off[ch] = ok & off_req[ch];

      // Disable or master reset aborts a running pulse
      dpc_chan u_chan (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_abort(dis | srst),
        .i_launch_on(launch_on[ch]),
        .i_launch_off(launch_off[ch]),
        .i_on_cyc(on_cycles(cfg_q[ch].on_sel)),
        .i_off_cyc(off_cycles(cfg_q[ch].off_sel)),
        .o_active(busy[ch]),
        .o_off_pulse(o_off_pulse[ch]),
        .o_done(done[ch])
      );

      // Off pulse forces open load detection for its duration
      assign ol_eff[ch] = ol_cfg[ch] | o_off_pulse[ch];

      // Priority latch: a lower code number is a higher priority
      wire [2:0] code = i_result_code[3*ch +: 3];
      wire clr = (ch < `DPC_HALF) ? rd_lo : rd_hi;
      wire [2:0] base = clr ? `DPC_ST_NOT_DONE : st_q[ch];
      wire olf_hidden = (code == `DPC_ST_OLF) & ~ol_eff[ch];
      assign accept[ch] = (i_result_valid[ch] | done[ch]) &
        (code != `DPC_ST_INVALID) & ~olf_hidden & (code < base);

      // A result arriving with the clearing read still lands
      always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) st_q[ch] <= `DPC_ST_NOT_DONE;
        else if (srst) st_q[ch] <= `DPC_ST_NOT_DONE;
        else if (accept[ch]) st_q[ch] <= code;
        else st_q[ch] <= base;
      end
    end
  endgenerate

  // ========================================================================
  // Status word: zeros, disable level, then bit planes of three codes
  wire [11:0] st_lo = {2'h0, dis,
    st_q[2][2], st_q[1][2], st_q[0][2],
    st_q[2][1], st_q[1][1], st_q[0][1],
    st_q[2][0], st_q[1][0], st_q[0][0]};
  wire [11:0] st_hi = {2'h0, dis,
    st_q[5][2], st_q[4][2], st_q[3][2],
    st_q[5][1], st_q[4][1], st_q[3][1],
    st_q[5][0], st_q[4][0], st_q[3][0]};

  // Answer for the next frame: status words, else echo of the data.
  // A refused frame answers with zero data and changes nothing.
  always_comb begin
    resp_d = resp_q;
    if (frame_end) begin
      resp_d.addr = rx_frame.addr;
      if (!rx_ok) resp_d.data = 12'h000;
      else if (rd_lo) resp_d.data = st_lo;
      else if (rd_hi) resp_d.data = st_hi;
      else resp_d.data = wdata;
      resp_d.parity = odd_par({resp_d.addr, resp_d.data});
    end
  end

  // Answer is held still between frames, which the link relies on
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) resp_q <= '0;
    else if (srst) resp_q <= '0;
    else resp_q <= resp_d;
  end

  // ========================================================================
  // Outputs towards the gate and analog front end
  assign o_pulse_invert = busy;
  assign o_openload_en = ol_eff & {6{~dis}};
  assign o_fast_charge_en = cfg2_q[`DPC_FC_EN] & {6{~dis}};
  assign o_ch_cfg = cfg_q;

  // ========================================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  sequence s_pulse_frame;
    wr_pulse && (launch_on != 6'h00);
  endsequence

  sequence s_pulse_runs;
    ((o_pulse_invert & $past(launch_on)) == $past(launch_on)) [*2];
  endsequence

  chk_launch_at_cs: assert property (s_pulse_frame |=> s_pulse_runs)
    else $error("on pulse did not start at frame end");
  chk_only_at_cs: assert property ((launch_on | launch_off) != 6'h00
    |-> $rose(cs_s2_q)) else $error("pulse launched mid frame");
  chk_pulse_reset: assert property (srst |=> pulse_q == `DPC_PULSE_RST)
    else $error("pulse register not cleared");
  chk_skip_disabled: assert property (dis |->
    (launch_on | launch_off) == 6'h00)
    else $error("pulse launched while disabled");
  chk_skip_both: assert property ((launch_on & launch_off) == 6'h00)
    else $error("both pulses launched");
  chk_skip_busy: assert property ((busy != 6'h00) |->
    ((launch_on | launch_off) & busy) == 6'h00)
    else $error("pulse relaunched while running");
  chk_cfg_none: assert property ((wr_cfg1 && chsel == `DPC_CHSEL_NONE)
    |=> cfg_q == $past(cfg_q)) else $error("select none changed");
  chk_cfg2_reset: assert property (srst |=> cfg2_q == `DPC_CFG2_RST)
    else $error("second config not reset");
  chk_status_word: assert property (rd_lo |=> resp_q.data[`DPC_ST_ZERO]
    == 2'h0 && resp_q.data[`DPC_ST_DIS_BIT] == $past(dis))
    else $error("status word layout wrong");
  chk_no_demote: assert property ((!rd_lo && !srst) |=>
    st_q[0] <= $past(st_q[0])) else $error("status demoted");
  chk_read_clears: assert property ((rd_hi && !accept[3]) |=>
    st_q[3] == `DPC_ST_NOT_DONE) else $error("read did not clear");
  chk_dis_keeps: assert property (($changed(dis) && !rd_lo &&
    !srst && !accept[1]) |=> $stable(st_q[1]))
    else $error("disable hit status");
  chk_ol_hidden: assert property ((i_result_code[5:3] == `DPC_ST_OLF &&
    !ol_eff[1] && st_q[1] != `DPC_ST_OLF && !srst) |=>
    st_q[1] != `DPC_ST_OLF) else $error("open load not hidden");
endmodule

/* tb/dpc_host_model.sv */
// Serial host model that sends frames to the register bank
`timescale 1ns/10ps
module dpc_host_model (
  output logic o_sclk,
  output logic o_chip_select_n,
  output logic o_mosi,
  input wire logic i_miso
);
  // ========================================================================
  // Link clock stands still while no frame is in flight
  initial begin
    o_sclk = 1'b0;
    o_chip_select_n = 1'b1;
    o_mosi = 1'b0;
  end

  // One frame MSB first; a returns the answer to the previous frame
  task automatic xfer(input logic [15:0] w, output logic [15:0] a);
    o_chip_select_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      o_mosi = w[i];
      #15;
      a[i] = i_miso;
      o_sclk = 1'b1;
      #15;
      o_sclk = 1'b0;
    end
    #15;
    o_chip_select_n = 1'b1;
    o_mosi = ~o_mosi; // Released line does not keep its last bit
    // Long gap so the frame is taken before the caller looks
    #400;
  endtask
endmodule

/* tb/tb_dpc_regs.sv */
// Self-checking bench of the diagnostic register bank
`timescale 1ns/10ps
module tb_dpc_regs;
  localparam int OFFL = 40;
  logic i_clk, i_arst_n, i_sclk, i_chip_select_n, i_mosi, o_miso, o_miso_oe;
  logic i_master_reset_n, i_global_disable_input;
  logic [5:0] i_retry_active, i_blank_active, i_result_valid;
  logic [17:0] i_result_code;
  logic [5:0] o_pulse_invert, o_off_pulse, o_openload_en, o_fast_charge_en;
  dpc_pkg::dpc_cfg_type [5:0] o_ch_cfg;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int hi_cnt [6];
  int ol_cnt = 0;
  logic [15:0] ans;

  // ========================================================================
  // Design and host
  dpc_regs #(.OFF_BLANK_LONG_CYC(OFFL)) u_dpc_regs (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(i_sclk),
    .i_chip_select_n(i_chip_select_n), .i_mosi(i_mosi), .o_miso(o_miso),
    .o_miso_oe(o_miso_oe), .i_master_reset_n(i_master_reset_n),
    .i_global_disable_input(i_global_disable_input),
    .i_retry_active(i_retry_active), .i_blank_active(i_blank_active),
    .i_result_valid(i_result_valid), .i_result_code(i_result_code),
    .o_pulse_invert(o_pulse_invert), .o_off_pulse(o_off_pulse),
    .o_openload_en(o_openload_en), .o_fast_charge_en(o_fast_charge_en),
    .o_ch_cfg(o_ch_cfg)
  );
  dpc_host_model u_dpc_host_model (
    .o_sclk(i_sclk), .o_chip_select_n(i_chip_select_n), .o_mosi(i_mosi),
    .i_miso(o_miso)
  );

  // Clock at 25 MHz
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  // Pulse length counters and the hang limit
  always @(posedge i_clk) begin
    cycles++;
    for (int c = 0; c < 6; c++) if (o_pulse_invert[c]) hi_cnt[c]++;
    if (o_off_pulse[1] && o_openload_en[1]) ol_cnt++;
    if (cycles == 20000) begin
      err_count++;
      finish_test();
    end
  end

  // ========================================================================
  // Helpers
  function automatic logic [15:0] mk(logic [2:0] a, logic [11:0] d);
    return {a, d, ~^{a, d}};
  endfunction
  function automatic logic [11:0] stw(logic s, logic [2:0] c2, c1, c0);
    return {2'b00, s, c2[2], c1[2], c0[2], c2[1], c1[1], c0[1],
      c2[0], c1[0], c0[0]};
  endfunction
  task automatic check(string n, logic [15:0] s, logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic frm(logic [2:0] a, logic [11:0] d);
    u_dpc_host_model.xfer(mk(a, d), ans);
  endtask
  task automatic strobe(int ch, logic [2:0] code);
    @(negedge i_clk);
    i_result_valid[ch] = 1'b1;
    i_result_code[3*ch +: 3] = code;
    @(negedge i_clk);
    i_result_valid = 6'h00;
  endtask
  task automatic cfg_all(logic [6:0] e);
    for (int c = 0; c < 6; c++) check("cfg", 16'(o_ch_cfg[c]), 16'(e));
  endtask

  // ========================================================================
  // Scenarios
  task automatic t_reset;
    cfg_all(7'h0a);
    check("ol", 16'(o_openload_en), 16'h003f);
    check("fc", 16'(o_fast_charge_en), 16'h0000);
    check("oe", 16'(o_miso_oe), 16'h0000);
    frm(3'h4, 12'h000);
    frm(3'h5, 12'h000);
    check("stlo", ans, mk(3'h4, 12'h1ff));
    frm(3'h0, 12'h000);
    check("sthi", ans, mk(3'h5, 12'h1ff));
    $display("test reset done");
  endtask

  task automatic t_status;
    strobe(0, 3'h3);
    strobe(0, 3'h4);
    strobe(2, 3'h2);
    strobe(2, 3'h1);
    strobe(1, 3'h0);
    frm(3'h4, 12'h000);
    frm(3'h4, 12'h000);
    check("held", ans, mk(3'h4, stw(1'b0, 3'h1, 3'h7, 3'h3)));
    frm(3'h0, 12'h000);
    check("clr", ans, mk(3'h4, 12'h1ff));
    $display("test status done");
  endtask

  task automatic t_cfg;
    frm(3'h2, 12'h1da);
    frm(3'h2, 12'h101);
    check("echo", ans, mk(3'h2, 12'h1da));
    frm(3'h3, 12'h0bd);
    frm(3'h0, 12'h000);
    check("echo2", ans, mk(3'h3, 12'h0bd));
    check("cfg0", 16'(o_ch_cfg[0]), 16'h0008);
    check("cfg1", 16'(o_ch_cfg[1]), 16'h000e);
    check("cfg2", 16'(o_ch_cfg[2]), 16'h000a);
    check("ol", 16'(o_openload_en), 16'h003d);
    check("fc", 16'(o_fast_charge_en), 16'h0002);
    $display("test config done");
  endtask

  task automatic t_pulse;
    strobe(1, 3'h3);
    i_result_code = {12'h000, 3'h6, 3'h5};
    i_blank_active = 6'h08;
    i_retry_active = 6'h10;
    hi_cnt = '{default: 0};
    ol_cnt = 0;
    frm(3'h1, 12'h19d);
    // Longer on time written while channel 0 still pulses
    frm(3'h2, 12'h121);
    check("pecho", ans, mk(3'h1, 12'h19d));
    repeat (200) @(posedge i_clk);
    for (int c = 0; c < 6; c++)
      check("len", 16'(hi_cnt[c]), 16'(c == 0 ? 150 : c == 1 ? OFFL : 0));
    check("olp", 16'(ol_cnt), 16'(OFFL));
    frm(3'h4, 12'h000);
    frm(3'h0, 12'h000);
    check("pst", ans, mk(3'h4, stw(1'b0, 3'h7, 3'h6, 3'h5)));
    @(negedge i_clk);
    i_blank_active = 6'h00;
    i_retry_active = 6'h00;
    hi_cnt[0] = 0;
    frm(3'h1, 12'h001);
    repeat (350) @(posedge i_clk);
    check("len2", 16'(hi_cnt[0]), 16'd300);
    $display("test pulse done");
  endtask

  task automatic t_disable;
    @(negedge i_clk);
    i_global_disable_input = 1'b1;
    strobe(0, 3'h1);
    hi_cnt[0] = 0;
    frm(3'h1, 12'h001);
    check("dol", 16'(o_openload_en), 16'h0000);
    frm(3'h5, 12'h000);
    frm(3'h0, 12'h000);
    check("dst", ans, mk(3'h5, stw(1'b1, 3'h7, 3'h7, 3'h7)));
    @(negedge i_clk);
    i_global_disable_input = 1'b0;
    frm(3'h1, 12'h001);
    frm(3'h4, 12'h000);
    frm(3'h0, 12'h000);
    check("kept", ans, mk(3'h4, stw(1'b0, 3'h7, 3'h7, 3'h1)));
    check("skip", 16'(hi_cnt[0]), 16'h0000);
    $display("test disable done");
  endtask

  task automatic t_select;
    for (int k = 1; k < 7; k++) begin
      frm(3'h2, {3'(k), 6'h28, 3'(k)});
      check("sel", 16'(o_ch_cfg[k-1]), 16'({3'(k), 4'ha}));
    end
    frm(3'h2, {3'h7, 6'h28, 3'h7});
    cfg_all(7'h7a);
    frm(3'h2, 12'h000);
    cfg_all(7'h7a);
    $display("test select done");
  endtask

  task automatic t_mreset;
    strobe(4, 3'h2);
    @(negedge i_clk);
    i_master_reset_n = 1'b0;
    repeat (5) @(negedge i_clk);
    i_master_reset_n = 1'b1;
    repeat (4) @(negedge i_clk);
    cfg_all(7'h0a);
    check("mol", 16'(o_openload_en), 16'h003f);
    frm(3'h5, 12'h000);
    frm(3'h0, 12'h000);
    check("mst", ans, mk(3'h5, 12'h1ff));
    $display("test master reset done");
  endtask

  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ========================================================================
  // Main sequence
  initial begin
    i_arst_n = 1'b0;
    i_master_reset_n = 1'b1;
    i_global_disable_input = 1'b0;
    i_retry_active = 6'h00;
    i_blank_active = 6'h00;
    i_result_valid = 6'h00;
    i_result_code = 18'h00000;
    repeat (3) @(negedge i_clk);
    i_arst_n = 1'b1;
    repeat (4) @(negedge i_clk);
    t_reset();
    t_status();
    t_cfg();
    t_pulse();
    t_disable();
    t_select();
    t_mreset();
    finish_test();
  end
endmodule
